//--- design/pixel_shift_pkg.sv
// Shared types and constants for the pixel digital shift datapath.
package pixel_shift_pkg;
   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int ADC_W = 10;
   localparam int OUT_W = 10;
   localparam int FIFO_DEPTH = 8;
   localparam int TOP_BIT = 9;
   localparam int SUB_BIT = 8;

   // ---------------------------------------------------------------
   // Mode encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SHIFT_OFF = 2'h0,
      SHIFT_ONCE = 2'h1,
      SHIFT_TWICE = 2'h2
   } shift_mode_t;

   localparam logic [ADC_W-1:0] SAMPLE_RESET = 10'h000;
   localparam logic [OUT_W-1:0] PIXEL_ONES = 10'h3FF;
   localparam logic [OUT_W-1:0] PIXEL_RESET = 10'h000;

   // One pixel with its frame markers.
   typedef struct packed {
      logic frame_start;
      logic frame_end;
      logic [ADC_W-1:0] value;
   } sample_t;

   typedef struct packed {
      logic frame_start;
      logic frame_end;
      logic [OUT_W-1:0] value;
   } pixel_t;

   localparam int PIXEL_W = OUT_W + 2;
endpackage

//--- design/pixel_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module pixel_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
   localparam logic [AW:0] CNT_ZERO = '0;
   localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
   localparam logic [AW-1:0] PTR_ONE = AW'(1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic [WIDTH-1:0] rd_data_reg;
   logic rd_valid_reg;

   wire full = (count_reg == DEPTH_CNT);
   wire empty = (count_reg == CNT_ZERO);
   wire push = in_valid && !full;
   wire load = !empty && (!rd_valid_reg || out_ready);
   wire pop_out = rd_valid_reg && out_ready;

   assign in_ready = !full;
   assign out_valid = rd_valid_reg;
   assign out_data = rd_data_reg;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         rd_data_reg <= '0;
         rd_valid_reg <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
         end
         if (load) begin
            rd_ptr_reg <= rd_ptr_reg + PTR_ONE;
            rd_data_reg <= mem_reg[rd_ptr_reg];
         end
         if (push && !load) begin
            count_reg <= count_reg + CNT_ONE;
         end else if (!push && load) begin
            count_reg <= count_reg - CNT_ONE;
         end
         if (load) begin
            rd_valid_reg <= 1'b1;
         end else if (pop_out) begin
            rd_valid_reg <= 1'b0;
         end
      end
   end

   chk_fifo_no_overfill: assert property (@(posedge core_clk) disable iff (rst)
      count_reg <= DEPTH_CNT) else $error("fifo count above depth");
endmodule

//--- design/pixel_digital_shift.sv
// Per-pixel digital shift and saturation from ADC sample to output word.
`timescale 1ns/1ps
// Functional notes
// - Accept one unsigned ten-bit sample per pixel, bit 9 down to bit 0.
// - Ten-bit width, shift off: pass all ten bits unchanged.
// - Ten-bit width, shift once: bits 8..0 then one zero bit.
// - Ten-bit width, shift twice: bits 7..0 then two zero bits.
// - Eight-bit width, shift off: output bits 9..2.
// - Eight-bit width, shift once: output bits 8..1.
// - Eight-bit width, shift twice: output bits 7..0.
// - Shift once with bit 9 set, or shift twice with bit 9 or 8 set, forces all ones.
// - Shift setting is chosen by a software-written mode field.
module pixel_digital_shift
   import pixel_shift_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Configuration from the control register file
   input wire logic [1:0] shift_mode,
   input wire logic eight_bit_mode,
   // Sample stream from the converter
   input wire logic in_valid,
   output logic in_ready,
   input wire logic in_frame_start,
   input wire logic in_frame_end,
   input wire logic [ADC_W-1:0] in_sample,
   // Pixel output stream
   output logic out_valid,
   input wire logic out_ready,
   output logic out_frame_start,
   output logic out_frame_end,
   output logic [OUT_W-1:0] out_pixel,
   // Active configuration
   output logic [1:0] active_mode
);
   // ---------------------------------------------------------------
   // Frame-aligned mode latch
   // ---------------------------------------------------------------
   shift_mode_t mode_reg;
   shift_mode_t mode_next;
   logic width8_reg;
   logic width8_next;
   logic stage_valid_reg;
   pixel_t stage_reg;
   pixel_t stage_next;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [PIXEL_W-1:0] fifo_out_data;
   pixel_t fifo_pixel;

   wire accept = in_valid && in_ready;
   wire stage_take = !stage_valid_reg || fifo_in_ready;
   // A frame's first pixel uses the freshly written mode; later pixels keep it.
   wire use_new = accept && in_frame_start;
   wire shift_mode_t req_mode = (shift_mode == 2'h3) ? SHIFT_OFF : shift_mode_t'(shift_mode);
   wire shift_mode_t eff_mode = use_new ? req_mode : mode_reg;
   wire eff_w8 = use_new ? eight_bit_mode : width8_reg;

   assign mode_next = eff_mode;
   assign width8_next = eff_w8;

   // ---------------------------------------------------------------
   // Registered input ready
   // ---------------------------------------------------------------
   // Ready leaves the block from a flop, so it is decided one cycle early from
   // the number of pixels held between the input and the output port.
   // Stopping at the FIFO depth costs one word of buffering, but a pixel taken
   // while ready is high always finds the stage free or able to move on.
   localparam int OCC_W = $clog2(FIFO_DEPTH) + 1;
   localparam logic [OCC_W-1:0] OCC_LIMIT = OCC_W'(FIFO_DEPTH);
   localparam logic [OCC_W-1:0] OCC_ONE = OCC_W'(1);

   logic [OCC_W-1:0] occ_reg;
   logic [OCC_W-1:0] occ_next;
   logic in_ready_reg;
   logic in_ready_next;

   wire drain = fifo_out_valid && out_ready;
   wire [OCC_W-1:0] occ_up = accept ? occ_reg + OCC_ONE : occ_reg;

   assign occ_next = drain ? occ_up - OCC_ONE : occ_up;
   assign in_ready_next = (occ_next <= OCC_LIMIT);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         occ_reg <= '0;
         in_ready_reg <= 1'b1;
      end else begin
         occ_reg <= occ_next;
         in_ready_reg <= in_ready_next;
      end
   end

   // ---------------------------------------------------------------
   // Bit window selection and saturation
   // ---------------------------------------------------------------
   wire [ADC_W-1:0] s = in_sample;
   wire sat_once = s[TOP_BIT];
   wire sat_twice = s[TOP_BIT] | s[SUB_BIT];
   wire [OUT_W-1:0] win10_off = s;
   wire [OUT_W-1:0] win10_once = {s[8:0], 1'b0};
   wire [OUT_W-1:0] win10_twice = {s[7:0], 2'b00};
   wire [OUT_W-1:0] win8_off = {2'b00, s[9:2]};
   wire [OUT_W-1:0] win8_once = {2'b00, s[8:1]};
   wire [OUT_W-1:0] win8_twice = {2'b00, s[7:0]};
   // Eight-bit words sit in the low bits, so saturation is eight ones there.
   wire [OUT_W-1:0] ones = eff_w8 ? {2'b00, PIXEL_ONES[7:0]} : PIXEL_ONES;
   wire [OUT_W-1:0] sel_off = eff_w8 ? win8_off : win10_off;
   wire [OUT_W-1:0] sel_once = sat_once ? ones : (eff_w8 ? win8_once : win10_once);
   wire [OUT_W-1:0] sel_twice = sat_twice ? ones : (eff_w8 ? win8_twice : win10_twice);

   logic [OUT_W-1:0] shifted;
   always_comb begin
      shifted = sel_off;
      unique case (eff_mode)
         SHIFT_OFF: shifted = sel_off;
         SHIFT_ONCE: shifted = sel_once;
         SHIFT_TWICE: shifted = sel_twice;
         default: shifted = sel_off;
      endcase
   end

   always_comb begin
      stage_next.frame_start = in_frame_start;
      stage_next.frame_end = in_frame_end;
      stage_next.value = shifted;
   end

   // The stage takes at most one pixel a cycle, and only while the registered occupancy ready is high.
   assign in_ready = in_ready_reg;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_reg <= SHIFT_OFF;
         width8_reg <= 1'b0;
      end else if (accept) begin
         mode_reg <= mode_next;
         width8_reg <= width8_next;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stage_valid_reg <= 1'b0;
         stage_reg <= '0;
      end else if (stage_take) begin
         stage_valid_reg <= accept;
         if (accept) begin
            stage_reg <= stage_next;
         end
      end
   end

   // ---------------------------------------------------------------
   // Output buffer
   // ---------------------------------------------------------------
   pixel_fifo #(
      .WIDTH(PIXEL_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(stage_valid_reg),
      .in_ready(fifo_in_ready),
      .in_data(stage_reg),
      .out_valid(fifo_out_valid),
      .out_ready(out_ready),
      .out_data(fifo_out_data)
   );

   assign fifo_pixel = pixel_t'(fifo_out_data);
   // FIFO outputs are its own read registers, so these stay flop-driven.
   assign out_valid = fifo_out_valid;
   assign out_frame_start = fifo_pixel.frame_start;
   assign out_frame_end = fifo_pixel.frame_end;
   assign out_pixel = fifo_pixel.value;
   assign active_mode = mode_reg;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   wire take10 = accept && stage_take && !eff_w8;
   wire take8 = accept && stage_take && eff_w8;

   chk_pass_ten_bits: assert property (
      take10 && eff_mode == SHIFT_OFF |=> stage_reg.value == $past(in_sample))
      else $error("ten-bit no-shift mismatch");
   chk_once_ten_window: assert property (
      take10 && eff_mode == SHIFT_ONCE && !in_sample[9]
      |=> stage_reg.value == {$past(in_sample[8:0]), 1'b0})
      else $error("ten-bit shift-once window wrong");
   chk_twice_ten_window: assert property (
      take10 && eff_mode == SHIFT_TWICE && in_sample[9:8] == 2'b00
      |=> stage_reg.value == {$past(in_sample[7:0]), 2'b00})
      else $error("ten-bit shift-twice window wrong");
   chk_off_eight_window: assert property (
      take8 && eff_mode == SHIFT_OFF |=> stage_reg.value[7:0] == $past(in_sample[9:2]))
      else $error("eight-bit no-shift window wrong");
   chk_once_eight_window: assert property (
      take8 && eff_mode == SHIFT_ONCE && !in_sample[9]
      |=> stage_reg.value[7:0] == $past(in_sample[8:1]))
      else $error("eight-bit shift-once window wrong");
   chk_twice_eight_window: assert property (
      take8 && eff_mode == SHIFT_TWICE && in_sample[9:8] == 2'b00
      |=> stage_reg.value[7:0] == $past(in_sample[7:0]))
      else $error("eight-bit shift-twice window wrong");
   chk_once_saturate: assert property (
      take10 && eff_mode == SHIFT_ONCE && in_sample[9] |=> stage_reg.value == 10'h3FF)
      else $error("shift-once saturation missing");
   chk_twice_saturate: assert property (
      take8 && eff_mode == SHIFT_TWICE && (in_sample[9] || in_sample[8])
      |=> stage_reg.value == 10'h0FF)
      else $error("shift-twice saturation missing");
   chk_mode_frame_hold: assert property (
      accept && !in_frame_start |=> mode_reg == $past(mode_reg))
      else $error("mode changed inside a frame");
   chk_mode_at_start: assert property (
      accept && in_frame_start && shift_mode != 2'h3 |=> mode_reg == $past(shift_mode))
      else $error("mode not taken at frame start");

   cov_once_sat: cover property (take10 && eff_mode == SHIFT_ONCE && in_sample[9]);
   cov_twice8: cover property (take8 && eff_mode == SHIFT_TWICE);
   cov_backpressure: cover property (stage_valid_reg && !fifo_in_ready);
   cov_mode_switch: cover property (accept && in_frame_start && req_mode != mode_reg);
   cov_refuse: cover property (in_valid && !in_ready);

   chk_ready_has_room: assert property (
      in_ready |-> stage_take)
      else $error("ready raised without room in the stage");
endmodule

//--- tb/pixel_sink.sv
// Downstream pixel path model that accepts pixels promptly, slowly or not at all.
`timescale 1ns/1ps
module pixel_sink (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Behaviour control from the bench
   input wire logic stall,
   input wire logic slow,
   // Accept strobe towards the block
   output logic out_ready
);
   logic [1:0] pace_reg;

   // Ready moves only just after an edge, like a registered downstream port.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pace_reg <= 2'h0;
         out_ready <= 1'b0;
      end else begin
         pace_reg <= pace_reg + 2'h1;
         out_ready <= !stall && (!slow || pace_reg == 2'h0);
      end
   end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the pixel digital shift datapath.
`timescale 1ns/1ps
module testbench;
   import pixel_shift_pkg::*;
   logic core_clk, rst, eight_bit_mode, in_valid, in_frame_start, in_frame_end;
   logic stall, slow, in_ready, out_valid, out_ready, out_frame_start, out_frame_end;
   logic saw_refuse, m_w8;
   logic [1:0] shift_mode, active_mode, m_mode;
   logic [ADC_W-1:0] in_sample;
   logic [OUT_W-1:0] out_pixel;
   logic [31:0] lfsr;
   int mismatches, cmp_count, sent, got;
   pixel_t exp_q[$];

   pixel_digital_shift DUT (.core_clk(core_clk), .rst(rst), .shift_mode(shift_mode),
      .eight_bit_mode(eight_bit_mode), .in_valid(in_valid), .in_ready(in_ready),
      .in_frame_start(in_frame_start), .in_frame_end(in_frame_end), .in_sample(in_sample),
      .out_valid(out_valid), .out_ready(out_ready), .out_frame_start(out_frame_start),
      .out_frame_end(out_frame_end), .out_pixel(out_pixel), .active_mode(active_mode));
   pixel_sink sink (.core_clk(core_clk), .rst(rst), .stall(stall), .slow(slow),
      .out_ready(out_ready));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   function automatic logic [31:0] next_rand(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   function automatic logic [OUT_W-1:0] model(logic [ADC_W-1:0] s, logic [1:0] m, logic w8);
      logic [OUT_W-1:0] ones;
      ones = w8 ? 10'h0FF : 10'h3FF;
      case (m)
         2'h1: return s[9] ? ones : (w8 ? {2'h0, s[8:1]} : {s[8:0], 1'b0});
         2'h2: return (s[9] | s[8]) ? ones : (w8 ? {2'h0, s[7:0]} : {s[7:0], 2'h0});
         default: return w8 ? {2'h0, s[9:2]} : s;
      endcase
   endfunction

   task automatic check(logic [11:0] seen, logic [11:0] expected);
      cmp_count++;
      if (seen !== expected) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, expected);
      end
   endtask

   task automatic complete_run();
      $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Holds the sample until an edge sees it taken; a long wait lifts the downstream stall.
   task automatic send(logic [ADC_W-1:0] s, logic fs, logic fe);
      int n;
      n = 0;
      in_valid <= 1'b1;
      in_sample <= s;
      in_frame_start <= fs;
      in_frame_end <= fe;
      do begin
         @(posedge core_clk);
         n++;
         if (n == 20) stall <= 1'b0;
      end while (in_ready !== 1'b1);
      sent++;
   endtask

   // ---------------------------------------------------------------
   // Reference model and scoreboard
   // ---------------------------------------------------------------
   always @(posedge core_clk) begin : scoreboard
      pixel_t e;
      if (!rst) begin
         if (in_ready === 1'b0) saw_refuse = 1'b1;
         if (in_valid && in_ready) begin
            check({10'h000, active_mode}, {10'h000, (m_mode == 2'h3) ? 2'h0 : m_mode});
            if (in_frame_start) begin
               m_mode = shift_mode;
               m_w8 = eight_bit_mode;
            end
            e.frame_start = in_frame_start;
            e.frame_end = in_frame_end;
            e.value = model(in_sample, m_mode, m_w8);
            exp_q.push_back(e);
         end
         if (out_valid && out_ready) begin
            got++;
            e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
            check({out_frame_start, out_frame_end, out_pixel}, e);
         end
      end
   end

   initial begin
      #2000000;
      mismatches++;
      complete_run();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {rst, eight_bit_mode, in_valid, in_frame_start, in_frame_end} = 5'h10;
      {stall, slow, saw_refuse, m_w8} = 4'h0;
      shift_mode = 2'h0;
      m_mode = 2'h0;
      in_sample = SAMPLE_RESET;
      lfsr = 32'h5B4C6367;
      repeat (10) @(posedge core_clk);
      check({in_ready, out_valid, out_pixel}, {2'h2, PIXEL_RESET});
      rst <= 1'b0;
      @(posedge core_clk);
      for (int f = 0; f < 10; f++) begin
         shift_mode <= f[1:0];
         eight_bit_mode <= f[2];
         stall <= (f == 5);
         slow <= (f == 2 || f == 6);
         for (int p = 0; p < 12; p++) begin
            lfsr = next_rand(lfsr);
            if (lfsr[13:12] == 2'h0) begin
               in_valid <= 1'b0;
               @(posedge core_clk);
            end
            // A mid-frame setting change must wait for the next frame.
            if (p == 6) {eight_bit_mode, shift_mode} <= lfsr[6:4];
            // The last frame keeps readings low enough for either shift.
            send((f == 9) ? {2'h0, lfsr[7:0]} : lfsr[9:0], p == 0, p == 11);
         end
      end
      in_valid <= 1'b0;
      stall <= 1'b0;
      for (int i = 0; i < 300 && got != sent; i++) @(posedge core_clk);
      check(12'(got), 12'(sent));
      check({11'h0, saw_refuse}, 12'h001);
      complete_run();
   end
endmodule
